// File: logic/ppp_fifo.sv
// Synchronous FIFO with valid and ready on both sides
module ppp_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Honest full and empty from the fill count
    assign in_ready_o = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Storage carries no reset
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and count
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= AW'(wr_q + 1'b1);
            end
            if (pop) begin
                rd_q <= AW'(rd_q + 1'b1);
            end
            cnt_q <= (AW+1)'(cnt_q + (AW+1)'(push) - (AW+1)'(pop));
        end
    end
endmodule : ppp_fifo

// File: logic/ppp_pkg.sv
// Package of constants and types for the parallel programming port
package ppp_pkg;
    // Action select coding
    localparam logic [1:0] PPP_ACT_ADDR = 2'h0;
    localparam logic [1:0] PPP_ACT_DATA = 2'h1;
    localparam logic [1:0] PPP_ACT_CMD = 2'h2;
    localparam logic [1:0] PPP_ACT_IDLE = 2'h3;
    // Command bytes
    localparam logic [7:0] PPP_CMD_NOP = 8'h00;
    localparam logic [7:0] PPP_CMD_ERASE = 8'h80;
    localparam logic [7:0] PPP_CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] PPP_CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] PPP_CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] PPP_CMD_WR_EEP = 8'h11;
    localparam logic [7:0] PPP_CMD_RD_SIG = 8'h08;
    localparam logic [7:0] PPP_CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] PPP_CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] PPP_CMD_RD_EEP = 8'h03;
    // Page geometry: 128 words per Flash page
    localparam int PPP_PAGE_WORDS = 128;
    localparam int PPP_WORD_BITS = 7;
    localparam int PPP_FIFO_DEPTH = 16;
    // Entry: strobe edges and settle time
    localparam logic [3:0] PPP_ENTRY_EDGES = 4'h6;
    localparam int PPP_SETTLE_NS = 100;
    localparam int PPP_CLK_NS = 25;
    localparam logic [3:0] PPP_SETTLE_CYC = 4'((PPP_SETTLE_NS + PPP_CLK_NS - 1) / PPP_CLK_NS);
    // Busy times in cycles (plain defaults)
    localparam logic [7:0] PPP_ERASE_CYC = 8'h40;
    localparam logic [7:0] PPP_PROG_CYC = 8'h20;
    // Reset values
    localparam logic [7:0] PPP_FUSE_RST = 8'hFF;
    localparam logic [7:0] PPP_LOCK_RST = 8'hFF;
    localparam logic [7:0] PPP_SIG_BYTE = 8'h5A; // Value arbitrary
    localparam logic [7:0] PPP_CAL_BYTE = 8'hA5; // Value arbitrary

    // Programmer side pins
    typedef struct packed {
        logic [1:0] action;
        logic byte_select_one;
        logic byte_select_two;
        logic page_load_strobe;
        logic wr_n;
        logic oe_n;
    } ppp_pins_t;

    // Memory write request carried to the array port
    typedef struct packed {
        logic flash;
        logic [15:0] addr;
        logic [15:0] data;
    } ppp_wreq_t;

    typedef enum logic [1:0] {
        PPP_ST_IDLE = 2'b00,
        PPP_ST_ERASE = 2'b01,
        PPP_ST_PROG = 2'b10
    } ppp_state_t;
endpackage : ppp_pkg

// File: logic/ppp_port.sv
// Parallel programming port: command, address and data loading, erase and page write
//
// Behaviour
// - Strobe edge action: address, data, command, idle
// - Byte select one picks address byte
// - Byte select one picks data byte
// - Decode write commands; write pulse executes command
// - Decode read commands for output data
// - Ready low while programming, high otherwise
// - Drive data bus only while oe low
// - Byte select two picks extra lane
// - Entry pins change in window: no entry
// - Command and address kept across operations
// - Erase clears flash, eeprom, locks; fuses kept
// - Preserve fuse keeps eeprom through erase
// - Write pulse starts erase, busy till done
// - Page load latches word into buffer
// - Low bits word, upper bits page
// - Write pulse with bs1 low writes page
// - Nop command resets write signals
module ppp_port
    import ppp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Programming pins
    input wire logic crystal_strobe_pin_i,
    input wire ppp_pins_t pins_i,
    input wire logic hv_reset_i,
    output logic ready_busy_out_o,
    // Bidirectional data bus
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    // Memory array side
    output logic mem_wr_valid_o,
    input wire logic mem_wr_ready_i,
    output ppp_wreq_t mem_wr_o,
    output logic erase_flash_o,
    output logic erase_eeprom_o,
    input wire logic [15:0] mem_rd_data_i,
    input wire logic eeprom_preserve_fuse_i,
    // Status
    output logic prog_mode_o,
    output logic [7:0] fuse_lo_o,
    output logic [7:0] fuse_hi_o,
    output logic [7:0] fuse_ext_o,
    output logic [7:0] lock_o
);
    ppp_state_t state_q;
    logic xs_q;
    logic wr_n_q;
    logic strobe_rise;
    logic wr_fall;
    logic [7:0] cmd_q;
    logic [15:0] addr_q;
    logic [15:0] data_q;
    logic [15:0] page_q [PPP_PAGE_WORDS];
    logic [PPP_PAGE_WORDS-1:0] page_vld_q;
    logic [PPP_WORD_BITS-1:0] scan_q;
    logic [7:0] busy_q;
    logic [3:0] edges_q;
    logic [3:0] settle_q;
    logic hv_q;
    logic [3:0] entry_pins_q;
    logic [3:0] entry_pins;
    logic fifo_ready;
    logic push_valid;
    logic [7:0] fuse_lo_q;
    logic [7:0] fuse_hi_q;
    logic [7:0] fuse_ext_q;
    logic [7:0] lock_q;
    logic [7:0] rd_byte;
    logic sig_cmd;

    // Write command decode, used by the sequencer
    function automatic logic is_write_cmd(input logic [7:0] c);
        return c == PPP_CMD_ERASE || c == PPP_CMD_WR_FUSE || c == PPP_CMD_WR_LOCK ||
               c == PPP_CMD_WR_FLASH || c == PPP_CMD_WR_EEP;
    endfunction

    // Edge detection; pins are synchronous to the clock
    assign strobe_rise = crystal_strobe_pin_i && !xs_q;
    assign wr_fall = !pins_i.wr_n && wr_n_q && prog_mode_o && state_q == PPP_ST_IDLE;
    assign entry_pins = {pins_i.page_load_strobe, pins_i.action, pins_i.byte_select_one};
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            xs_q <= 1'b0;
            wr_n_q <= 1'b1;
        end else begin
            xs_q <= crystal_strobe_pin_i;
            wr_n_q <= pins_i.wr_n;
        end
    end

    // Entry: count strobe edges while reset is low, then demand stable zero pins after high voltage
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            edges_q <= '0;
            settle_q <= '0;
            hv_q <= 1'b0;
            entry_pins_q <= '0;
            prog_mode_o <= 1'b0;
        end else begin
            hv_q <= hv_reset_i;
            entry_pins_q <= entry_pins;
            if (!hv_reset_i) begin
                prog_mode_o <= 1'b0;
                settle_q <= '0;
                if (strobe_rise && edges_q != PPP_ENTRY_EDGES) begin
                    edges_q <= edges_q + 4'h1;
                end
            end else if (!hv_q) begin
                // Pins must be zero when high voltage arrives
                settle_q <= (edges_q == PPP_ENTRY_EDGES && entry_pins == '0) ? 4'h1 : 4'h0;
                edges_q <= '0;
            end else if (settle_q != '0 && !prog_mode_o) begin
                if (entry_pins != entry_pins_q || entry_pins != '0) begin
                    settle_q <= '0;
                end else if (settle_q == PPP_SETTLE_CYC) begin
                    prog_mode_o <= 1'b1;
                end else begin
                    settle_q <= settle_q + 4'h1;
                end
            end
        end
    end

    // Command, address and data loading; loaded values stay until overwritten
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cmd_q <= PPP_CMD_NOP;
            addr_q <= '0;
            data_q <= '0;
        end else if (prog_mode_o && strobe_rise) begin
            case (pins_i.action)
                PPP_ACT_ADDR: begin
                    if (pins_i.byte_select_one) begin
                        addr_q[15:8] <= data_i;
                    end else begin
                        addr_q[7:0] <= data_i;
                    end
                end
                PPP_ACT_DATA: begin
                    if (pins_i.byte_select_one) begin
                        data_q[15:8] <= data_i;
                    end else begin
                        data_q[7:0] <= data_i;
                    end
                end
                PPP_ACT_CMD: cmd_q <= data_i;
                default: ;
            endcase
        end
    end

    // Page buffer: latch on page load with bs1 high; nop or a finished write clears the valid map
    always_ff @(posedge ref_clk_i) begin
        if (prog_mode_o && pins_i.page_load_strobe && pins_i.byte_select_one && state_q == PPP_ST_IDLE) begin
            page_q[addr_q[PPP_WORD_BITS-1:0]] <= data_q;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            page_vld_q <= '0;
        end else begin
            if (prog_mode_o && strobe_rise && pins_i.action == PPP_ACT_CMD && data_i == PPP_CMD_NOP) begin
                page_vld_q <= '0;
            end else if (state_q == PPP_ST_PROG && busy_q == 8'h01) begin
                page_vld_q <= '0;
            end
            if (prog_mode_o && pins_i.page_load_strobe && pins_i.byte_select_one &&
                state_q == PPP_ST_IDLE) begin          // Latch beside a clear survives: set wins
                page_vld_q[addr_q[PPP_WORD_BITS-1:0]] <= 1'b1;
            end
        end
    end

    // Sequencer: erase and page/fuse/lock programming
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= PPP_ST_IDLE;
            busy_q <= '0;
            scan_q <= '0;
        end else begin
            case (state_q)
                PPP_ST_IDLE: begin
                    scan_q <= '0;
                    if (wr_fall && cmd_q == PPP_CMD_ERASE) begin
                        state_q <= PPP_ST_ERASE;
                        busy_q <= PPP_ERASE_CYC;
                    end else if (wr_fall && is_write_cmd(cmd_q)) begin
                        state_q <= PPP_ST_PROG;
                        busy_q <= PPP_PROG_CYC;
                    end
                end
                PPP_ST_ERASE: begin
                    busy_q <= busy_q - 8'h01;
                    if (busy_q == 8'h01) begin
                        state_q <= PPP_ST_IDLE;
                    end
                end
                PPP_ST_PROG: begin
                    // Walk the buffer first; back-pressure from the FIFO stalls the walk
                    if (!push_valid || fifo_ready) begin
                        scan_q <= PPP_WORD_BITS'(scan_q + 1'b1);
                    end
                    if (scan_q == '1 && (!push_valid || fifo_ready)) begin
                        busy_q <= busy_q - 8'h01;
                    end else if (busy_q != PPP_PROG_CYC) begin
                        busy_q <= busy_q - 8'h01;
                    end
                    if (busy_q == 8'h01) begin
                        state_q <= PPP_ST_IDLE;
                    end
                end
                default: state_q <= PPP_ST_IDLE;
            endcase
        end
    end

    // Ready low while a programming step is busy
    assign ready_busy_out_o = state_q == PPP_ST_IDLE;

    // Erase strobes; eeprom spared when the preserve fuse is programmed (low)
    assign erase_flash_o = state_q == PPP_ST_ERASE && busy_q == PPP_ERASE_CYC;
    assign erase_eeprom_o = erase_flash_o && eeprom_preserve_fuse_i;

    // Fuses, locks: locks clear only at the end of erase, after the array is gone
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fuse_lo_q <= PPP_FUSE_RST;
            fuse_hi_q <= PPP_FUSE_RST;
            fuse_ext_q <= PPP_FUSE_RST;
            lock_q <= PPP_LOCK_RST;
        end else if (state_q == PPP_ST_ERASE && busy_q == 8'h01) begin
            lock_q <= PPP_LOCK_RST;
        end else if (wr_fall && cmd_q == PPP_CMD_WR_LOCK) begin
            lock_q <= data_q[7:0];
        end else if (wr_fall && cmd_q == PPP_CMD_WR_FUSE) begin
            if (pins_i.byte_select_two) begin
                fuse_ext_q <= data_q[7:0];
            end else if (pins_i.byte_select_one) begin
                fuse_hi_q <= data_q[7:0];
            end else begin
                fuse_lo_q <= data_q[7:0];
            end
        end
    end
    assign fuse_lo_o = fuse_lo_q;
    assign fuse_hi_o = fuse_hi_q;
    assign fuse_ext_o = fuse_ext_q;
    assign lock_o = lock_q;

    // Only buffered words of a Flash page write are pushed into the FIFO toward the array
    logic [32:0] push_data;
    logic [15:0] page_addr;
    assign page_addr = {addr_q[15:PPP_WORD_BITS], scan_q};
    assign push_valid = state_q == PPP_ST_PROG && cmd_q == PPP_CMD_WR_FLASH && page_vld_q[scan_q] &&
                        busy_q == PPP_PROG_CYC;
    assign push_data = {1'b1, page_addr, page_q[scan_q]};
    ppp_fifo #(.WIDTH(33), .DEPTH(PPP_FIFO_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .in_valid_i(push_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(push_data),
        .out_valid_o(mem_wr_valid_o),
        .out_ready_i(mem_wr_ready_i),
        .out_data_o(mem_wr_o)
    );

    // Read data selection by command and byte selects
    assign sig_cmd = cmd_q == PPP_CMD_RD_SIG;
    always_comb begin
        rd_byte = 8'h00;
        if (cmd_q == PPP_CMD_RD_FLASH) begin
            rd_byte = pins_i.byte_select_one ? mem_rd_data_i[15:8] : mem_rd_data_i[7:0];
        end else if (cmd_q == PPP_CMD_RD_EEP) begin
            rd_byte = mem_rd_data_i[7:0];
        end else if (sig_cmd) begin
            rd_byte = pins_i.byte_select_one ? PPP_CAL_BYTE : PPP_SIG_BYTE;
        end else if (cmd_q == PPP_CMD_RD_FUSE) begin
            case ({pins_i.byte_select_two, pins_i.byte_select_one})
                2'b00: rd_byte = fuse_lo_q;
                2'b11: rd_byte = fuse_hi_q;
                2'b10: rd_byte = fuse_ext_q;
                default: rd_byte = lock_q;
            endcase
        end
    end

    // Registered bus drive while oe is low
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
        end else begin
            data_o <= rd_byte;
            data_oe_o <= prog_mode_o && !pins_i.oe_n;
        end
    end

    // Checks
    sequence erase_start_s;
        wr_fall && cmd_q == PPP_CMD_ERASE;
    endsequence
    sequence busy_hold_s;
        !ready_busy_out_o [*8];
    endsequence
    erase_busy_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        erase_start_s |=> busy_hold_s) else $error("erase did not hold busy");
    erase_done_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        erase_start_s |-> ##65 ready_busy_out_o) else $error("erase length wrong");
    prog_busy_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (wr_fall && cmd_q == PPP_CMD_WR_FUSE) |=> !ready_busy_out_o) else $error("no busy on write");
    oe_drive_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        data_oe_o |-> $past(!pins_i.oe_n)) else $error("bus driven without oe");
    addr_low_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (prog_mode_o && strobe_rise && pins_i.action == PPP_ACT_ADDR && !pins_i.byte_select_one)
        |=> addr_q[7:0] == $past(data_i)) else $error("low address not loaded");
    data_high_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (prog_mode_o && strobe_rise && pins_i.action == PPP_ACT_DATA && pins_i.byte_select_one)
        |=> data_q[15:8] == $past(data_i)) else $error("high data not loaded");
    cmd_keep_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !strobe_rise |=> cmd_q == $past(cmd_q)) else $error("command changed");
    lock_clear_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        erase_start_s |-> ##65 lock_q == PPP_LOCK_RST) else $error("locks not cleared");
    eep_keep_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !eeprom_preserve_fuse_i |-> !erase_eeprom_o) else $error("eeprom erased");
endmodule : ppp_port

// File: tb/ppp_mem_model.sv
// Memory array stand-in: takes page writes with selectable stalls, returns a fixed read word
module ppp_mem_model
    import ppp_pkg::*;
#(
    parameter logic [15:0] RD_WORD = 16'hC396
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Write side; mode 0 prompt, 1 every other cycle, 2 hold off
    input wire logic [1:0] mode_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire ppp_wreq_t wr_i,
    // Read side
    output logic [15:0] rd_data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    ppp_wreq_t log_q[$];
    logic tick_q;

    // Stall pattern and write log; holding off lets the buffer fill up behind us
    always_ff @(posedge ref_clk_i) begin
        tick_q <= srst_i ? 1'b0 : ~tick_q;
        if (!srst_i && wr_valid_i && wr_ready_o) begin
            log_q.push_back(wr_i);
        end
    end

    // Ready follows the chosen stall mode
    assign wr_ready_o = (mode_i == 2'h0) || (mode_i == 2'h1 && tick_q);
    assign rd_data_o = RD_WORD;
endmodule // ppp_mem_model

// File: tb/testbench.sv
// Self-checking bench for the parallel programming port
module testbench
    import ppp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic crystal = 1'b0;
    logic hv = 1'b0;
    logic preserve = 1'b1;
    logic [1:0] mode = 2'h0;
    ppp_pins_t pins = 7'h03;
    logic [7:0] tb_data = 8'h00;
    logic [7:0] bus, data_o, f_lo, f_hi, f_ext, lock;
    logic data_oe, ready, mem_v, mem_r, prog_mode, er_f, er_e;
    ppp_wreq_t mem_w;
    logic [15:0] rd;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_ef = 0;
    int n_ee = 0;

    // Bus level: the port wins while it drives, otherwise the programmer's byte
    assign bus = data_oe ? data_o : tb_data;

    ppp_port i_ppp_port (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .crystal_strobe_pin_i(crystal),
        .pins_i(pins), .hv_reset_i(hv), .ready_busy_out_o(ready), .data_i(bus), .data_o(data_o),
        .data_oe_o(data_oe), .mem_wr_valid_o(mem_v), .mem_wr_ready_i(mem_r), .mem_wr_o(mem_w),
        .erase_flash_o(er_f), .erase_eeprom_o(er_e), .mem_rd_data_i(rd),
        .eeprom_preserve_fuse_i(preserve), .prog_mode_o(prog_mode), .fuse_lo_o(f_lo),
        .fuse_hi_o(f_hi), .fuse_ext_o(f_ext), .lock_o(lock));

    ppp_mem_model i_ppp_mem_model (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .mode_i(mode),
        .wr_valid_i(mem_v), .wr_ready_o(mem_r), .wr_i(mem_w), .rd_data_o(rd));

    // Clock at 40 MHz
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    // Erase pulse counters and hang guard
    always @(posedge ref_clk_i) begin
        cycles++;
        if (er_f === 1'b1) n_ef++;
        if (er_e === 1'b1) n_ee++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Inputs always move 2 ns after the edge
    task automatic step(int n = 1);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask

    task automatic check_val(logic [15:0] got, logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(logic got, logic exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: flag got %h expected %h", $time, got, exp);
        end
    endtask

    // One strobe rise with the action, byte select one and data set up beforehand
    task automatic load(logic [1:0] act, logic bs1, logic [7:0] d);
        pins.action = act;
        pins.byte_select_one = bs1;
        tb_data = d;
        step();
        crystal = 1'b1;
        step();
        crystal = 1'b0;
        step();
    endtask

    task automatic pulse_wr();
        pins.wr_n = 1'b0;
        step();
        pins.wr_n = 1'b1;
    endtask

    // Waits for busy to show, then counts the busy cycles under a bound
    task automatic wait_ready(output int lo);
        int w;
        lo = 0;
        w = 0;
        while (ready === 1'b1 && w < 4) begin
            step();
            w++;
        end
        while (ready !== 1'b1 && lo < 5000) begin
            step();
            lo++;
        end
    endtask

    // Drives output enable low with the selects, checks the bus, then releases it
    task automatic rd_chk(logic bs2, logic bs1, logic [7:0] exp);
        pins.byte_select_two = bs2;
        pins.byte_select_one = bs1;
        pins.oe_n = 1'b0;
        step(2);
        check_bit(data_oe, 1'b1);
        check_val(16'(bus), 16'(exp));
        pins.oe_n = 1'b1;
        step(2);
        check_bit(data_oe, 1'b0);
        pins.byte_select_two = 1'b0;
    endtask

    // Entry: strobes with reset low, pins at zero, then the high voltage; a glitch spoils it
    task automatic enter(logic glitch);
        hv = 1'b0;
        pins = 7'h03;
        repeat (6) load(PPP_ACT_ADDR, 1'b0, 8'h00);
        step(4);
        hv = 1'b1;
        if (glitch) begin
            step();
            pins.byte_select_one = 1'b1;
            step();
            pins.byte_select_one = 1'b0;
        end
        step(12);
    endtask

    // Main sequence
    initial begin
        int lo;
        int ef0;
        int ee0;
        step(6);
        srst_i = 1'b0;
        step();
        check_bit(ready, 1'b1);
        check_val(16'(lock), 16'h00FF);
        enter(1'b1);
        check_bit(prog_mode, 1'b0);
        enter(1'b0);
        check_bit(prog_mode, 1'b1);
        // Three fuse lanes chosen by the byte selects, then the lock byte
        load(PPP_ACT_CMD, 1'b0, PPP_CMD_WR_FUSE);
        for (int k = 0; k < 3; k++) begin
            load(PPP_ACT_DATA, 1'b0, 8'h12 + 8'(k));
            pins.byte_select_one = (k == 1);
            pins.byte_select_two = (k == 2);
            pulse_wr();
            wait_ready(lo);
        end
        pins.byte_select_two = 1'b0;
        check_val({f_lo, f_hi}, 16'h1213);
        check_val(16'(f_ext), 16'h0014);
        load(PPP_ACT_CMD, 1'b0, PPP_CMD_WR_LOCK);
        load(PPP_ACT_DATA, 1'b0, 8'hFC);
        pulse_wr();
        wait_ready(lo);
        check_val(16'(lock), 16'h00FC);
        load(PPP_ACT_CMD, 1'b0, PPP_CMD_RD_FUSE);
        rd_chk(1'b0, 1'b0, 8'h12);
        rd_chk(1'b1, 1'b1, 8'h13);
        rd_chk(1'b1, 1'b0, 8'h14);
        rd_chk(1'b0, 1'b1, 8'hFC);
        // An idle-coded strobe must leave the loaded command alone
        load(PPP_ACT_CMD, 1'b0, PPP_CMD_RD_SIG);
        load(PPP_ACT_IDLE, 1'b0, PPP_CMD_ERASE);
        rd_chk(1'b0, 1'b0, PPP_SIG_BYTE);
        rd_chk(1'b0, 1'b1, PPP_CAL_BYTE);
        load(PPP_ACT_CMD, 1'b0, PPP_CMD_RD_FLASH);
        rd_chk(1'b0, 1'b0, 8'h96);
        rd_chk(1'b0, 1'b1, 8'hC3);
        // Chip erase with the preserve fuse programmed, then unprogrammed
        for (int p = 0; p < 2; p++) begin
            preserve = p[0];
            ef0 = n_ef;
            ee0 = n_ee;
            load(PPP_ACT_CMD, 1'b0, PPP_CMD_ERASE);
            pulse_wr();
            wait_ready(lo);
            check_val(16'(lo), 16'(PPP_ERASE_CYC));
            check_val(16'(n_ef - ef0), 16'h0001);
            check_val(16'(n_ee - ee0), 16'(p));
            check_val({lock, f_hi}, 16'hFF13);
        end
        // Locks are clear again, so the clock-source nibble of the low fuse may be rewritten
        load(PPP_ACT_CMD, 1'b0, PPP_CMD_WR_FUSE);
        load(PPP_ACT_DATA, 1'b0, 8'hE0);
        pulse_wr();
        wait_ready(lo);
        check_val(16'(f_lo), 16'h00E0);
        // Page of 20 words in the upper half of the low byte, array side holding off
        mode = 2'h2;
        load(PPP_ACT_CMD, 1'b0, PPP_CMD_WR_FLASH);
        load(PPP_ACT_ADDR, 1'b1, 8'h03);
        for (int i = 0; i < 20; i++) begin
            load(PPP_ACT_ADDR, 1'b0, 8'h80 + 8'(i));
            load(PPP_ACT_DATA, 1'b0, 8'(i) ^ 8'h5C);
            load(PPP_ACT_DATA, 1'b1, 8'h30 + 8'(i));
            pins.page_load_strobe = 1'b1;
            step();
            pins.page_load_strobe = 1'b0;
            step();
        end
        pins.byte_select_one = 1'b0;
        pulse_wr();
        step(200);
        check_bit(ready, 1'b0);
        check_bit(mem_v, 1'b1);
        mode = 2'h1;
        wait_ready(lo);
        check_bit(ready, 1'b1);
        check_val(16'(i_ppp_mem_model.log_q.size()), 16'h0014);
        for (int i = 0; i < 20; i++) begin
            check_val(i_ppp_mem_model.log_q[i].addr, {8'h03, 8'h80 + 8'(i)});
            check_val(i_ppp_mem_model.log_q[i].data, {8'h30 + 8'(i), 8'(i) ^ 8'h5C});
            check_bit(i_ppp_mem_model.log_q[i].flash, 1'b1);
        end
        // A word latched before the no-operation command must not be written afterwards
        pins.byte_select_one = 1'b1;
        pins.page_load_strobe = 1'b1;
        step();
        pins.page_load_strobe = 1'b0;
        load(PPP_ACT_CMD, 1'b0, PPP_CMD_NOP);
        load(PPP_ACT_CMD, 1'b0, PPP_CMD_WR_FLASH);
        pulse_wr();
        wait_ready(lo);
        check_val(16'(i_ppp_mem_model.log_q.size()), 16'h0014);
        wrap_up();
    end
endmodule // testbench
